// [pkg/usmf_pkg.sv]
// Shared constants for the serial buffer, status and address filter block
package usmf_pkg;
  // Register byte offsets on the bus
  localparam logic [4:0] OFS_DATA = 5'h00; // Shared data window
  localparam logic [4:0] OFS_STAT_A = 5'h04; // Status register A
  localparam logic [4:0] OFS_CTRL_B = 5'h08; // Control register B
  localparam logic [4:0] OFS_CTRL_C = 5'h0C; // Frame format register
  localparam logic [4:0] OFS_BAUD = 5'h10; // Baud divider
  // Reset values
  localparam logic [7:0] RST_STAT_A = 8'h20; // Buffer empty only
  localparam logic [7:0] RST_CTRL_B = 8'h00;
  localparam logic [7:0] RST_CTRL_C = 8'h06; // Eight data bits
  localparam logic [11:0] RST_BAUD = 12'h000;
  // Status register A bit positions
  localparam int SA_RXC = 7;
  localparam int SA_TXC = 6;
  localparam int SA_UDRE = 5;
  localparam int SA_FE = 4;
  localparam int SA_DOR = 3;
  localparam int SA_PE = 2;
  localparam int SA_U2X = 1;
  localparam int SA_FILT = 0;
  // Control register B bit positions
  localparam int CB_RXCIE = 7;
  localparam int CB_TXCIE = 6;
  localparam int CB_UDRIE = 5;
  localparam int CB_RXEN = 4;
  localparam int CB_TXEN = 3;
  localparam int CB_SIZE2 = 2;
  localparam int CB_RX9 = 1;
  localparam int CB_TX9 = 0;
  // Frame format register bit positions
  localparam int CC_MODE_LO = 6;
  localparam int CC_PAR_ON = 5;
  localparam int CC_PAR_ODD = 4;
  localparam int CC_STOP2 = 3;
  localparam int CC_SIZE_LO = 1;
  // Samples per bit in normal and double speed
  localparam logic [4:0] SPB_NORMAL = 5'h10;
  localparam logic [4:0] SPB_DOUBLE = 5'h08;
  // Character size codes and lengths
  localparam logic [2:0] SIZE_NINE = 3'h7;
  localparam logic [3:0] LEN_FIVE = 4'h5;
  localparam logic [3:0] LEN_EIGHT = 4'h8;
  localparam logic [3:0] LEN_NINE = 4'h9;
  localparam logic [8:0] MASK_ALL = 9'h1FF;
  // Receiver states
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS, RX_STOP} usmf_rx_e;
endpackage : usmf_pkg

// [logic/usmf_rx.sv]
// Receive shifter: builds one frame from the serial input, stepping once per baud tick
module usmf_rx (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic enable,
  input wire logic serial_in_pin,
  input wire logic tick,
  input wire logic [4:0] spb,
  input wire logic [3:0] nbits,
  input wire logic parity_check_on,
  input wire logic par_odd,
  output logic start_seen,
  output logic frame_valid,
  output logic [8:0] frame_data,
  output logic frame_stop,
  output logic frame_perr
);
  usmf_pkg::usmf_rx_e state_r; // Receiver state
  logic [4:0] smp_r; // Sample counter within a bit
  logic [3:0] idx_r; // Bit index in the frame
  logic [9:0] sh_r; // Data and parity bits by position
  logic [3:0] total; // Data bits plus parity
  logic [8:0] mask; // Valid data bits
  logic par_bit; // Received parity bit

  assign total = nbits + {3'h0, parity_check_on};
  assign mask = 9'(usmf_pkg::MASK_ALL >> (usmf_pkg::LEN_NINE - nbits));
  assign par_bit = sh_r[nbits];

  // Frame sequencer; upper unused bits leave as zero
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= usmf_pkg::RX_IDLE;
      smp_r <= 5'h00;
      idx_r <= 4'h0;
      sh_r <= 10'h000;
      start_seen <= 1'b0;
      frame_valid <= 1'b0;
      frame_data <= 9'h000;
      frame_stop <= 1'b0;
      frame_perr <= 1'b0;
    end else begin
      start_seen <= 1'b0;
      frame_valid <= 1'b0;
      if (!enable) begin
        state_r <= usmf_pkg::RX_IDLE;
      end else if (tick) begin
        case (state_r)
          usmf_pkg::RX_IDLE: begin
            // A low line level on a tick starts a frame
            if (!serial_in_pin) begin
              state_r <= usmf_pkg::RX_START;
              smp_r <= 5'h01;
              start_seen <= 1'b1;
            end
          end
          usmf_pkg::RX_START: begin
            // Check the start bit at its centre
            if (smp_r == (spb >> 1)) begin
              state_r <= serial_in_pin ? usmf_pkg::RX_IDLE
                                       : usmf_pkg::RX_BITS;
              smp_r <= 5'h01;
              idx_r <= 4'h0;
              sh_r <= 10'h000;
            end else begin
              smp_r <= smp_r + 5'h01;
            end
          end
          usmf_pkg::RX_BITS: begin
            // Sample each bit at its centre
            if (smp_r == spb) begin
              sh_r[idx_r] <= serial_in_pin;
              smp_r <= 5'h01;
              idx_r <= idx_r + 4'h1;
              if (idx_r == total - 4'h1) begin
                state_r <= usmf_pkg::RX_STOP;
              end
            end else begin
              smp_r <= smp_r + 5'h01;
            end
          end
          usmf_pkg::RX_STOP: begin
            // Only the first stop bit is looked at
            if (smp_r == spb) begin
              state_r <= usmf_pkg::RX_IDLE;
              frame_valid <= 1'b1;
              frame_data <= sh_r[8:0] & mask;
              frame_stop <= serial_in_pin;
              frame_perr <= parity_check_on
                & (^(sh_r[8:0] & mask) ^ par_bit ^ par_odd);
            end else begin
              smp_r <= smp_r + 5'h01;
            end
          end
          default: state_r <= usmf_pkg::RX_IDLE;
        endcase
      end
    end
  end
endmodule : usmf_rx

// [logic/usmf_top.sv]
// Serial buffers, status flags and address filter with Wishbone registers
module usmf_top #(
  parameter int RX_DEPTH = 2 // Receive FIFO entries
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [4:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic serial_in_pin,
  output logic serial_out_pin,
  output logic serial_out_en,
  input wire logic cpu_global_irq_en,
  input wire logic tx_irq_ack,
  output logic rx_irq,
  output logic tx_irq,
  output logic udre_irq
);
  localparam int PW = $clog2(RX_DEPTH); // Pointer width
  localparam logic [PW:0] DEPTH_C = (PW + 1)'(RX_DEPTH);

  // Bus decode
  logic req; // New request this cycle
  logic wr_lane0; // Write hitting byte lane 0
  logic rd_data; // Read of the data window
  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  // Effects land at the acked edge, where the master still holds the request
  assign wr_lane0 = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & wb_sel_i[0];
  assign rd_data = wb_cyc_i & wb_stb_i & wb_ack_o & ~wb_we_i
                 & (wb_adr_i == usmf_pkg::OFS_DATA);

  // Software controlled state
  logic txc_r; // Transmit complete
  logic u2x_r; // Double speed select
  logic filt_r; // Address filter enable
  logic [7:0] ctrl_b_r; // Control register B writable bits
  logic [7:0] ctrl_c_r; // Frame format
  logic [11:0] baud_r; // Baud divider
  logic baud_reload; // Prescaler restart on divider write

  // Receive FIFO with per-entry error bits
  logic [8:0] fifo_dat [RX_DEPTH]; // Data including ninth bit
  logic [RX_DEPTH-1:0] fifo_fe; // Frame error per entry
  logic [RX_DEPTH-1:0] fifo_pe; // Parity error per entry
  logic [PW-1:0] wr_ptr_r; // Write pointer
  logic [PW-1:0] rd_ptr_r; // Read pointer
  logic [PW:0] count_r; // Stored entries
  logic dor_r; // Overrun flag
  logic pend_r; // Character waiting in shift register
  logic [8:0] pend_dat_r; // Waiting character
  logic pend_fe_r; // Waiting frame error
  logic pend_pe_r; // Waiting parity error

  // Transmit side
  logic [8:0] txb_r; // Holding buffer with ninth bit
  logic txb_full_r; // Holding buffer occupied
  logic [12:0] tsh_r; // Frame being shifted, start first
  logic [3:0] tleft_r; // Bits left in frame
  logic [4:0] tsmp_r; // Sample counter for current bit
  logic tbusy_r; // Shifter busy

  // Frame format decode
  logic [2:0] size_code; // Combined size code
  logic [3:0] nbits; // Data bits per frame
  logic [4:0] spb; // Samples per bit
  logic [11:0] bcnt_r; // Prescaler
  logic tick; // One sample period
  logic fifo_full; // All RX_DEPTH entries used
  logic rd_pop; // Head leaves the FIFO
  assign size_code = {ctrl_b_r[usmf_pkg::CB_SIZE2],
                      ctrl_c_r[usmf_pkg::CC_SIZE_LO+1:usmf_pkg::CC_SIZE_LO]};
  always_comb begin
    // Reserved codes fall back to eight bits
    if (size_code == usmf_pkg::SIZE_NINE) begin
      nbits = usmf_pkg::LEN_NINE;
    end else if (size_code[2]) begin
      nbits = usmf_pkg::LEN_EIGHT;
    end else begin
      nbits = usmf_pkg::LEN_FIVE + {2'h0, size_code[1:0]};
    end
  end
  // Double speed only in asynchronous mode
  assign spb = (u2x_r && ctrl_c_r[usmf_pkg::CC_MODE_LO+1:usmf_pkg::CC_MODE_LO]
                == 2'h0) ? usmf_pkg::SPB_DOUBLE
                         : usmf_pkg::SPB_NORMAL;
  assign tick = (bcnt_r == 12'h000);
  assign baud_reload = wr_lane0 & (wb_adr_i == usmf_pkg::OFS_BAUD);
  assign fifo_full = (count_r == DEPTH_C);
  assign rd_pop = rd_data & (count_r != '0);

  // Baud prescaler, restarted when the divider is written
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      bcnt_r <= 12'h000;
    end else if (baud_reload || tick) begin
      bcnt_r <= baud_reload ? wb_dat_i[11:0] : baud_r;
    end else begin
      bcnt_r <= bcnt_r - 12'h001;
    end
  end

  // Receive engine
  logic rx_start; // Start bit seen
  logic rx_valid; // Frame complete
  logic [8:0] rx_dat; // Frame data
  logic rx_stop; // First stop bit
  logic rx_perr; // Parity mismatch
  logic rx_type; // Frame type bit
  logic rx_keep; // Frame survives the filter
  logic rx_en; // Receiver enable
  assign rx_en = ctrl_b_r[usmf_pkg::CB_RXEN];
  usmf_rx u_rx (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .enable(rx_en),
    .serial_in_pin(serial_in_pin),
    .tick(tick),
    .spb(spb),
    .nbits(nbits),
    .parity_check_on(ctrl_c_r[usmf_pkg::CC_PAR_ON]),
    .par_odd(ctrl_c_r[usmf_pkg::CC_PAR_ODD]),
    .start_seen(rx_start),
    .frame_valid(rx_valid),
    .frame_data(rx_dat),
    .frame_stop(rx_stop),
    .frame_perr(rx_perr)
  );
  // Type from ninth bit or first stop bit
  assign rx_type = (nbits == usmf_pkg::LEN_NINE) ? rx_dat[8]
                                                  : rx_stop;
  // Data frames dropped while filtering; address frames kept
  assign rx_keep = rx_valid & (~filt_r | rx_type);

  // FIFO pointers, pending character and overrun
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
      pend_r <= 1'b0;
      dor_r <= 1'b0;
    end else if (!rx_en) begin
      // Disable flushes and clears errors
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
      pend_r <= 1'b0;
      dor_r <= 1'b0;
    end else begin
      if (rd_pop) begin
        rd_ptr_r <= PW'((rd_ptr_r + 1'b1) % RX_DEPTH);
      end
      // Pending character refills the slot freed by a read
      if ((rx_keep && (!fifo_full || rd_pop)) || (pend_r && rd_pop)) begin
        wr_ptr_r <= PW'((wr_ptr_r + 1'b1) % RX_DEPTH);
        if (!rd_pop) begin
          count_r <= count_r + 1'b1;
        end
      end else if (rd_pop) begin
        count_r <= count_r - 1'b1;
      end
      if (pend_r && rd_pop) begin
        pend_r <= rx_keep;
      end else if (rx_keep && fifo_full && !rd_pop) begin
        pend_r <= 1'b1;
      end
      // Overrun waits for a read of the buffer
      if (fifo_full && pend_r && rx_start) begin
        dor_r <= 1'b1;
      end else if (rd_pop) begin
        dor_r <= 1'b0;
      end
    end
  end

  // FIFO and pending storage, error bits kept per entry
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < RX_DEPTH; i++) begin
        fifo_dat[i] <= 9'h000;
      end
      fifo_fe <= '0;
      fifo_pe <= '0;
      pend_dat_r <= 9'h000;
      pend_fe_r <= 1'b0;
      pend_pe_r <= 1'b0;
    end else begin
      if (pend_r && rd_pop) begin
        fifo_dat[wr_ptr_r] <= pend_dat_r;
        fifo_fe[wr_ptr_r] <= pend_fe_r;
        fifo_pe[wr_ptr_r] <= pend_pe_r;
      end else if (rx_keep && (!fifo_full || rd_pop)) begin
        fifo_dat[wr_ptr_r] <= rx_dat;
        fifo_fe[wr_ptr_r] <= ~rx_stop;
        fifo_pe[wr_ptr_r] <= rx_perr;
      end
      if (rx_keep && fifo_full) begin
        pend_dat_r <= rx_dat;
        pend_fe_r <= ~rx_stop;
        pend_pe_r <= rx_perr;
      end
    end
  end

  // Head flags
  logic rxc; // Unread data present
  logic fe_head; // Frame error of head
  logic pe_head; // Parity error of head
  assign rxc = (count_r != '0);
  assign fe_head = rxc & fifo_fe[rd_ptr_r];
  assign pe_head = rxc & fifo_pe[rd_ptr_r];

  // Software registers; error bits are read only
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      u2x_r <= 1'b0;
      filt_r <= 1'b0;
      ctrl_b_r <= usmf_pkg::RST_CTRL_B;
      ctrl_c_r <= usmf_pkg::RST_CTRL_C;
      baud_r <= usmf_pkg::RST_BAUD;
    end else if (wr_lane0) begin
      case (wb_adr_i)
        usmf_pkg::OFS_STAT_A: begin
          u2x_r <= wb_dat_i[usmf_pkg::SA_U2X];
          filt_r <= wb_dat_i[usmf_pkg::SA_FILT];
        end
        usmf_pkg::OFS_CTRL_B: begin
          ctrl_b_r <= wb_dat_i[7:0];
        end
        usmf_pkg::OFS_CTRL_C: begin
          ctrl_c_r <= wb_dat_i[7:0];
        end
        usmf_pkg::OFS_BAUD: begin
          baud_r <= wb_dat_i[11:0];
        end
        default: ;
      endcase
    end
  end

  // Transmit holding buffer; writes ignored while occupied
  logic tx_load; // Buffer moves into the shifter
  logic tx_en; // Transmitter enable
  assign tx_en = ctrl_b_r[usmf_pkg::CB_TXEN];
  assign tx_load = txb_full_r & ~tbusy_r & tx_en;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      txb_r <= 9'h000;
      txb_full_r <= 1'b0;
    end else if (wr_lane0 && wb_adr_i == usmf_pkg::OFS_DATA
                 && !txb_full_r) begin
      txb_r <= {ctrl_b_r[usmf_pkg::CB_TX9], wb_dat_i[7:0]};
      txb_full_r <= 1'b1;
    end else if (tx_load) begin
      txb_full_r <= 1'b0;
    end
  end

  // Transmit frame built from size, parity and stop setting only
  logic [12:0] tframe; // Assembled frame, start bit at bit 0
  logic [3:0] tlen; // Frame length in bits
  logic [8:0] tdat; // Data bits in use
  always_comb begin
    tdat = txb_r & 9'(usmf_pkg::MASK_ALL >> (usmf_pkg::LEN_NINE - nbits));
    tframe = {4'hF, tdat} << 1;
    tframe[nbits + 4'h1] = ctrl_c_r[usmf_pkg::CC_PAR_ON]
      ? (^tdat ^ ctrl_c_r[usmf_pkg::CC_PAR_ODD]) : 1'b1;
    tlen = nbits + 4'h2 + {3'h0, ctrl_c_r[usmf_pkg::CC_PAR_ON]}
         + {3'h0, ctrl_c_r[usmf_pkg::CC_STOP2]};
  end

  // Transmit shifter, LSB first
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      tsh_r <= 13'h1FFF;
      tleft_r <= 4'h0;
      tsmp_r <= 5'h00;
      tbusy_r <= 1'b0;
    end else if (tx_load) begin
      tsh_r <= tframe;
      tleft_r <= tlen;
      tsmp_r <= 5'h00;
      tbusy_r <= 1'b1;
    end else if (tbusy_r && tick) begin
      if (tsmp_r == spb - 5'h01) begin
        tsmp_r <= 5'h00;
        tsh_r <= {1'b1, tsh_r[12:1]};
        tleft_r <= tleft_r - 4'h1;
        tbusy_r <= (tleft_r != 4'h1);
      end else begin
        tsmp_r <= tsmp_r + 5'h01;
      end
    end
  end

  // Transmit complete: set wins over ack or write-one clear
  logic tx_done; // Last bit just left with nothing waiting
  assign tx_done = tbusy_r & tick & (tsmp_r == spb - 5'h01)
                 & (tleft_r == 4'h1) & ~txb_full_r;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      txc_r <= 1'b0;
    end else if (tx_done) begin
      txc_r <= 1'b1;
    end else if (tx_irq_ack || (wr_lane0 && wb_adr_i == usmf_pkg::OFS_STAT_A
                 && wb_dat_i[usmf_pkg::SA_TXC])) begin
      txc_r <= 1'b0;
    end
  end

  // Read mux, bus answer and pin drivers
  logic [7:0] stat_a; // Status register A image
  logic [31:0] rd_mux; // Read data
  assign stat_a = {rxc, txc_r, ~txb_full_r, fe_head, dor_r, pe_head,
                   u2x_r, filt_r};
  always_comb begin
    case (wb_adr_i)
      usmf_pkg::OFS_DATA: rd_mux = {24'h0, fifo_dat[rd_ptr_r][7:0]
                                    & {8{rxc}}};
      usmf_pkg::OFS_STAT_A: rd_mux = {24'h0, stat_a};
      usmf_pkg::OFS_CTRL_B: rd_mux = {24'h0, ctrl_b_r[7:2],
                                      rxc & fifo_dat[rd_ptr_r][8],
                                      ctrl_b_r[0]};
      usmf_pkg::OFS_CTRL_C: rd_mux = {24'h0, ctrl_c_r};
      usmf_pkg::OFS_BAUD: rd_mux = {20'h0, baud_r};
      default: rd_mux = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      serial_out_pin <= 1'b1;
      serial_out_en <= 1'b0;
      rx_irq <= 1'b0;
      tx_irq <= 1'b0;
      udre_irq <= 1'b0;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= req ? rd_mux : 32'h0000_0000;
      serial_out_pin <= tsh_r[0];
      // Pin held until pending work drains
      serial_out_en <= tx_en | tbusy_r | txb_full_r;
      rx_irq <= ctrl_b_r[usmf_pkg::CB_RXCIE] & cpu_global_irq_en
              & rxc;
      tx_irq <= ctrl_b_r[usmf_pkg::CB_TXCIE] & cpu_global_irq_en
              & txc_r;
      udre_irq <= ctrl_b_r[usmf_pkg::CB_UDRIE] & cpu_global_irq_en
                & ~txb_full_r;
    end
  end

  // Checks
  a_filter_drops: assert property (@(posedge ref_clk) disable iff (!nrst)
    rx_en && rx_valid && filt_r && !rx_type && !rd_pop
    |=> count_r == $past(count_r))
    else $error("data frame stored while filtering");
  a_addr_kept: assert property (@(posedge ref_clk) disable iff (!nrst)
    rx_valid && rx_type && rx_en && count_r == '0 && !rd_pop |=> rxc)
    else $error("address frame not stored");
  a_full_write_ign: assert property (@(posedge ref_clk) disable iff (!nrst)
    txb_full_r && !tx_load |=> txb_r == $past(txb_r))
    else $error("busy buffer overwritten");
  a_rx_disable: assert property (@(posedge ref_clk) disable iff (!nrst)
    !rx_en |=> !rxc && !dor_r && !fe_head && !pe_head)
    else $error("disable did not flush");
  a_txc_set: assert property (@(posedge ref_clk) disable iff (!nrst)
    tx_done |=> txc_r)
    else $error("transmit complete missed");
  a_rx_irq: assert property (@(posedge ref_clk) disable iff (!nrst)
    rx_irq |-> $past(rxc) && $past(cpu_global_irq_en))
    else $error("receive interrupt without cause");
  a_pop_read: assert property (@(posedge ref_clk) disable iff (!nrst)
    rx_en && rd_pop && !rx_keep && !pend_r
    |=> count_r == $past(count_r) - 1'b1)
    else $error("read did not advance fifo");
  a_load_shift: assert property (@(posedge ref_clk) disable iff (!nrst)
    tx_load |=> tbusy_r && !txb_full_r ##1 !serial_out_pin)
    else $error("load did not start frame");
endmodule : usmf_top

// [sim/usmf_node.sv]
// Model of another serial node that drives the shared receive line
module usmf_node #(
  parameter int BIT_CLKS = 16 // Clocks per bit at the slave's rate
) (
  input wire logic ref_clk,
  output logic line
);
  timeunit 1ns;
  timeprecision 1ps;

  // Line rests high between frames
  initial begin
    line = 1'h1;
  end

  // Start, data lsb first, type-marking stop, then a second stop
  task automatic send(input logic [8:0] data, input int nbits,
                      input logic stop1);
    logic v;
    for (int n = 0; n < nbits + 3; n++) begin
      if (n == 0) begin
        v = 1'h0;
      end else if (n <= nbits) begin
        v = data[n-1]; // Ninth bit marks the frame type
      end else if (n == nbits + 1) begin
        v = stop1; // First stop marks the frame type
      end else begin
        v = 1'h1; // Second stop keeps the frame legal
      end
      @(posedge ref_clk);
      line <= v;
      repeat (BIT_CLKS - 1) @(posedge ref_clk);
    end
  endtask : send
endmodule : usmf_node

// [sim/tb_usmf_top.sv]
// Self-checking bench for the serial buffer, status and filter block
module tb_usmf_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, nrst, cyc, stb, we, gie, ack, rxd, txd, rx_irq, tx_irq;
  logic [4:0] adr;
  logic [31:0] wdat, rdat, rd;
  logic [7:0] b;
  logic got;
  logic oe, udre, tack;
  int err_count, samples_checked, cycles;

  usmf_top usmf_top_inst (.ref_clk(ref_clk), .nrst(nrst), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat),
    .wb_sel_i(4'hF), .wb_dat_o(rdat), .wb_ack_o(ack), .serial_in_pin(rxd),
    .serial_out_pin(txd), .serial_out_en(oe), .cpu_global_irq_en(gie),
    .tx_irq_ack(tack), .rx_irq(rx_irq), .tx_irq(tx_irq), .udre_irq(udre));
  usmf_node #(.BIT_CLKS(16)) usmf_node_inst (.ref_clk(ref_clk), .line(rxd));

  // Free-running clock, 8 ns period
  initial begin
    ref_clk = 1'h0;
    forever #4 ref_clk = ~ref_clk;
  end

  // Hang guard
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    if (err_count == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : wrap_up

  task automatic check(input logic [31:0] seen, exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: %s seen %h want %h", $time, what, seen, exp);
    end
  endtask : check

  // One classic Wishbone cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge ref_clk);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge ref_clk);
      t++;
    end while (ack !== 1'h1 && t < 50);
    rd = rdat;
    check(t < 50, 1'h1, "bus ack");
    if (t >= 50) begin
      wrap_up();
    end
    cyc <= 1'h0;
    stb <= 1'h0;
  endtask : wb

  // Samples one 8N1 frame from the transmit pin at mid-bit, bc clocks a bit
  task automatic grab(output logic [7:0] v, output logic ok, input int bc);
    int t;
    t = 0;
    ok = 1'h0;
    while (txd !== 1'h0 && t < 400) begin
      @(posedge ref_clk);
      t++;
    end
    if (t < 400) begin
      ok = 1'h1;
      repeat (bc / 2) @(posedge ref_clk);
      for (int i = 0; i < 8; i++) begin
        repeat (bc) @(posedge ref_clk);
        v[i] = txd;
      end
      repeat (bc) @(posedge ref_clk);
      check(txd, 1'h1, "stop bit");
      repeat (bc / 2) @(posedge ref_clk);
    end
  endtask : grab

  // Filter drops data frames, keeps the address frame
  task automatic s_filter();
    wb(1'h1, usmf_pkg::OFS_CTRL_B, 32'h90);
    wb(1'h1, usmf_pkg::OFS_STAT_A, 32'h01);
    usmf_node_inst.send(9'h03C, 8, 1'h0);
    usmf_node_inst.send(9'h0A5, 8, 1'h1);
    repeat (4) @(posedge ref_clk);
    check(rx_irq, 1'h1, "rx irq");
    wb(1'h0, usmf_pkg::OFS_STAT_A, 32'h0);
    check(rd[7:0], 8'hA1, "status after address");
    wb(1'h0, usmf_pkg::OFS_DATA, 32'h0);
    check(rd, 32'hA5, "address byte");
    wb(1'h0, usmf_pkg::OFS_STAT_A, 32'h0);
    check(rd[7], 1'h0, "data frame dropped");
  endtask : s_filter

  // Two-entry FIFO order, per-entry frame error, short characters
  task automatic s_fifo();
    wb(1'h1, usmf_pkg::OFS_STAT_A, 32'h00);
    usmf_node_inst.send(9'h011, 8, 1'h0);
    usmf_node_inst.send(9'h0F2, 8, 1'h1);
    wb(1'h0, usmf_pkg::OFS_STAT_A, 32'h0);
    check(rd[7:0], 8'hB0, "head has frame error");
    wb(1'h0, usmf_pkg::OFS_DATA, 32'h0);
    check(rd, 32'h11, "first entry");
    wb(1'h0, usmf_pkg::OFS_STAT_A, 32'h0);
    check(rd[7:0], 8'hA0, "second head clean");
    wb(1'h0, usmf_pkg::OFS_DATA, 32'h0);
    check(rd, 32'hF2, "second entry");
    wb(1'h1, usmf_pkg::OFS_CTRL_C, 32'h00);
    usmf_node_inst.send(9'h1FF, 5, 1'h1);
    wb(1'h0, usmf_pkg::OFS_DATA, 32'h0);
    check(rd, 32'h1F, "five-bit char");
    wb(1'h0, usmf_pkg::OFS_STAT_A, 32'h0);
    check(rd[7], 1'h0, "fifo empty");
    wb(1'h1, usmf_pkg::OFS_CTRL_C, 32'h06);
  endtask : s_fifo

  // Parity error, overrun on a fourth start bit, flush on disable
  task automatic s_errors();
    wb(1'h1, usmf_pkg::OFS_CTRL_C, 32'h26);
    usmf_node_inst.send(9'h103, 9, 1'h1);
    wb(1'h0, usmf_pkg::OFS_STAT_A, 32'h0);
    check(rd[7:0], 8'hA4, "parity error");
    wb(1'h0, usmf_pkg::OFS_DATA, 32'h0);
    check(rd, 32'h03, "parity char");
    wb(1'h1, usmf_pkg::OFS_CTRL_C, 32'h06);
    usmf_node_inst.send(9'h0A1, 8, 1'h1);
    usmf_node_inst.send(9'h0A2, 8, 1'h1);
    usmf_node_inst.send(9'h0A3, 8, 1'h1);
    usmf_node_inst.send(9'h0A4, 8, 1'h1);
    wb(1'h0, usmf_pkg::OFS_STAT_A, 32'h0);
    check(rd[7:0], 8'hA8, "overrun");
    wb(1'h0, usmf_pkg::OFS_DATA, 32'h0);
    check(rd, 32'hA1, "oldest entry");
    wb(1'h0, usmf_pkg::OFS_STAT_A, 32'h0);
    check(rd[3], 1'h0, "overrun cleared by read");
    wb(1'h1, usmf_pkg::OFS_CTRL_B, 32'h80);
    wb(1'h0, usmf_pkg::OFS_STAT_A, 32'h0);
    check(rd[7:0], 8'h20, "disable flushes");
  endtask : s_errors

  // Nine-bit frames: ninth bit marks address, selected slave opens filter
  task automatic s_nine();
    wb(1'h1, usmf_pkg::OFS_CTRL_B, 32'h94);
    wb(1'h1, usmf_pkg::OFS_STAT_A, 32'h01);
    usmf_node_inst.send(9'h0A5, 9, 1'h1);
    usmf_node_inst.send(9'h1C7, 9, 1'h1);
    wb(1'h0, usmf_pkg::OFS_CTRL_B, 32'h0);
    check(rd[1], 1'h1, "ninth bit of head");
    wb(1'h0, usmf_pkg::OFS_DATA, 32'h0);
    check(rd, 32'hC7, "only address kept");
    wb(1'h1, usmf_pkg::OFS_STAT_A, 32'h00);
    usmf_node_inst.send(9'h03C, 9, 1'h1);
    wb(1'h0, usmf_pkg::OFS_CTRL_B, 32'h0);
    check(rd[1], 1'h0, "data frame type");
    wb(1'h0, usmf_pkg::OFS_DATA, 32'h0);
    check(rd, 32'h3C, "selected slave data");
  endtask : s_nine

  // Full buffer refuses a write; send with filter on; complete flag
  task automatic s_tx();
    wb(1'h1, usmf_pkg::OFS_CTRL_B, 32'h40);
    wb(1'h1, usmf_pkg::OFS_STAT_A, 32'h01);
    wb(1'h1, usmf_pkg::OFS_DATA, 32'hC3);
    wb(1'h0, usmf_pkg::OFS_STAT_A, 32'h0);
    check(rd[5], 1'h0, "buffer full");
    wb(1'h1, usmf_pkg::OFS_DATA, 32'h3C);
    wb(1'h1, usmf_pkg::OFS_CTRL_B, 32'h48);
    grab(b, got, 16);
    check(b, 8'hC3, "sent byte");
    check(oe, 1'h1, "pin driven");
    grab(b, got, 16);
    check(got, 1'h0, "refused write sent");
    wb(1'h0, usmf_pkg::OFS_STAT_A, 32'h0);
    check(rd[7:0], 8'h61, "tx complete");
    check(tx_irq, 1'h1, "tx irq");
    gie <= 1'h0;
    repeat (2) @(posedge ref_clk);
    check(tx_irq, 1'h0, "tx irq masked");
    gie <= 1'h1;
    tack <= 1'h1;
    @(posedge ref_clk);
    tack <= 1'h0;
    wb(1'h0, usmf_pkg::OFS_STAT_A, 32'h0);
    check(rd[6], 1'h0, "cleared by interrupt");
    wb(1'h1, usmf_pkg::OFS_STAT_A, 32'h03);
    wb(1'h1, usmf_pkg::OFS_DATA, 32'h5A);
    grab(b, got, 8);
    check(b, 8'h5A, "double speed byte");
    wb(1'h1, usmf_pkg::OFS_STAT_A, 32'h41);
    wb(1'h0, usmf_pkg::OFS_STAT_A, 32'h0);
    check(rd[7:0], 8'h21, "tx complete cleared");
    wb(1'h1, usmf_pkg::OFS_CTRL_B, 32'h28);
    repeat (2) @(posedge ref_clk);
    check(udre, 1'h1, "empty irq");
  endtask : s_tx

  // Reset, then each scenario in turn
  initial begin
    nrst = 1'h0;
    {cyc, stb, we, adr, wdat, tack} = '0;
    gie = 1'h1;
    repeat (3) @(posedge ref_clk);
    nrst <= 1'h1;
    wb(1'h0, usmf_pkg::OFS_STAT_A, 32'h0);
    check(rd, {24'h0, usmf_pkg::RST_STAT_A}, "status reset");
    check(oe, 1'h0, "pin released");
    check(udre, 1'h0, "empty irq off");
    wb(1'h0, 5'h1C, 32'h0);
    check(rd, 32'h0, "unmapped read");
    s_filter();
    s_fifo();
    s_errors();
    s_nine();
    s_tx();
    wrap_up();
  end
endmodule : tb_usmf_top
